// ===== src/core_status_flag_logic.sv
// Purpose: Status flags of an 8-bit core: time-out, power-down, zero,
//   half-carry and carry, with a small register port
// Assumes: All inputs synchronous to clk; srst is the power-on or
//   brown-out reset, other_reset covers every other reset cause
// Notes: Flag register at offset 0, reset-cause bit at offset 1
`timescale 1ns/1ps
module core_status_flag_logic
  import status_flag_pkg::*;
(
  input wire logic clk, // Core clock, 200 MHz
  input wire logic srst, // Power-on or brown-out reset
  input wire logic ce, // Clock enable, low freezes all state
  input wire logic other_reset, // Any non power-on reset, one cycle
  input wire status_flag_pkg::core_event_type core_event, // Core events
  input wire status_flag_pkg::alu_req_type alu_req, // Instruction result
  input wire status_flag_pkg::reg_req_type reg_req, // Register access
  output logic [status_flag_pkg::DATA_W-1:0] rdata, // Read data
  output logic [status_flag_pkg::DATA_W-1:0] alu_result, // ALU sum, difference or logic result
  output logic timeout_flag, // Time-out flag
  output logic powerdown_flag, // Power-down flag
  output logic zero_flag, // Zero flag
  output logic half_carry_flag, // Half-carry or inverted borrow
  output logic carry_flag // Carry or inverted borrow
);
  import status_flag_pkg::*;

  logic [DATA_W-1:0] addend;
  logic carry_in;
  logic [NIBBLE_W:0] low_sum;
  logic [DATA_W:0] full_sum;
  logic arith_op;
  logic flag_update;
  logic next_zero;
  logic next_half_carry;
  logic next_carry;
  logic flag_write;
  logic [DATA_W-1:0] status_view;
  logic other_reset_seen;

  // Subtract reuses the adder; the carry-in completes two's complement
  always_comb
  begin
    arith_op = (alu_req.op == op_add) || (alu_req.op == op_sub);
    if (alu_req.op == op_sub)
    begin
      addend = ~alu_req.operand_b;
      carry_in = 1'b1;
    end
    else
    begin
      addend = alu_req.operand_b;
      carry_in = 1'b0;
    end
    low_sum = {1'b0, alu_req.operand_a[NIBBLE_W-1:0]}
      + {1'b0, addend[NIBBLE_W-1:0]}
      + {{NIBBLE_W{1'b0}}, carry_in};
    full_sum = {1'b0, alu_req.operand_a} + {1'b0, addend}
      + {{DATA_W{1'b0}}, carry_in};
  end

  // Carries straight from the sum give inverted borrow on subtract
  always_comb
  begin
    flag_update = ce && (alu_req.op != op_none);
    next_half_carry = low_sum[NIBBLE_W];
    next_carry = full_sum[DATA_W];
    if (arith_op)
      next_zero = (full_sum[DATA_W-1:0] == '0);
    else
      next_zero = (alu_req.logic_result == '0);
  end

  assign flag_write = reg_req.write && (reg_req.addr == STATUS_FLAGS_OFFSET);

  always_ff @(posedge clk)
  begin
    if (srst)
      alu_result <= '0;
    else if (ce && alu_req.op != op_none)
    begin
      if (arith_op)
        alu_result <= full_sum[DATA_W-1:0];
      else
        alu_result <= alu_req.logic_result;
    end
  end

  // Watchdog time-out wins over a clear instruction in the same cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      timeout_flag <= TIMEOUT_RESET;
    else if (ce)
    begin
      if (core_event.watchdog_timeout)
        timeout_flag <= 1'b0;
      else if (core_event.watchdog_clear_instr || core_event.sleep_instr)
        timeout_flag <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      powerdown_flag <= POWERDOWN_RESET;
    else if (ce)
    begin
      if (core_event.sleep_instr)
        powerdown_flag <= 1'b0;
      else if (core_event.watchdog_clear_instr)
        powerdown_flag <= 1'b1;
    end
  end

  // Instruction result takes priority over a software write
  always_ff @(posedge clk)
  begin
    if (srst)
      {zero_flag, half_carry_flag, carry_flag} <= ARITH_FLAGS_RESET;
    else if (ce && !other_reset)
    begin
      if (flag_update)
      begin
        zero_flag <= next_zero;
        if (arith_op)
        begin
          half_carry_flag <= next_half_carry;
          carry_flag <= next_carry;
        end
      end
      else if (flag_write)
      begin
        zero_flag <= reg_req.wdata[ZERO_BIT];
        half_carry_flag <= reg_req.wdata[HALF_CARRY_BIT];
        carry_flag <= reg_req.wdata[CARRY_BIT];
      end
    end
  end

  // Remembers that a non power-on reset has happened since power-on
  always_ff @(posedge clk)
  begin
    if (srst)
      other_reset_seen <= 1'b0;
    else if (ce && other_reset)
      other_reset_seen <= 1'b1;
  end

  always_comb
  begin
    status_view = '0;
    status_view[TIMEOUT_BIT] = timeout_flag;
    status_view[POWERDOWN_BIT] = powerdown_flag;
    status_view[ZERO_BIT] = zero_flag;
    status_view[HALF_CARRY_BIT] = half_carry_flag;
    status_view[CARRY_BIT] = carry_flag;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= '0;
    else if (ce)
    begin
      if (!reg_req.read)
        rdata <= '0;
      else if (reg_req.addr == STATUS_FLAGS_OFFSET)
        rdata <= status_view;
      else if (reg_req.addr == RESET_CAUSE_OFFSET)
        rdata <= {{(DATA_W-1){1'b0}}, other_reset_seen};
      else
        rdata <= UNMAPPED_READ;
    end
  end

  sequence s_sleep_seen;
    ce && core_event.sleep_instr && !core_event.watchdog_timeout;
  endsequence

  sequence s_events_quiet;
    ce && !core_event.watchdog_clear_instr && !core_event.sleep_instr
      && !core_event.watchdog_timeout;
  endsequence

  sequence s_add_taken;
    ce && !other_reset && alu_req.op == op_add;
  endsequence

  sequence s_sub_taken;
    ce && !other_reset && alu_req.op == op_sub;
  endsequence

  sequence s_logic_taken;
    ce && !other_reset && alu_req.op == op_logic;
  endsequence

  // A software write lands only when no instruction result competes
  sequence s_flag_write_taken;
    ce && !other_reset && alu_req.op == op_none && reg_req.write
      && reg_req.addr == STATUS_FLAGS_OFFSET;
  endsequence

  a_timeout_on_wdt: assert property (
    @(posedge clk) disable iff (srst)
    ce && core_event.watchdog_timeout |=> !timeout_flag)
    else $error("time-out flag not cleared by watchdog time-out");

  a_timeout_set: assert property (
    @(posedge clk) disable iff (srst)
    ce && core_event.watchdog_clear_instr && !core_event.watchdog_timeout
    |=> timeout_flag)
    else $error("watchdog clear did not set time-out flag");

  a_timeout_hold: assert property (
    @(posedge clk) disable iff (srst)
    s_events_quiet |=> $stable(timeout_flag))
    else $error("time-out flag moved with no core event");

  a_sleep_flags: assert property (
    @(posedge clk) disable iff (srst)
    s_sleep_seen |=> timeout_flag && !powerdown_flag)
    else $error("sleep did not set time-out and clear power-down");

  a_wdt_clear_pd: assert property (
    @(posedge clk) disable iff (srst)
    ce && core_event.watchdog_clear_instr && !core_event.sleep_instr
    |=> powerdown_flag)
    else $error("watchdog clear did not set power-down");

  a_powerdown_hold: assert property (
    @(posedge clk) disable iff (srst)
    s_events_quiet |=> $stable(powerdown_flag))
    else $error("power-down flag moved with no core event");

  a_half_carry_add: assert property (
    @(posedge clk) disable iff (srst)
    s_add_taken |=> half_carry_flag == (($past(alu_req.operand_a[3:0])
      + $past(alu_req.operand_b[3:0])) > 5'h0F))
    else $error("half-carry wrong after add");

  a_sub_no_borrow: assert property (
    @(posedge clk) disable iff (srst)
    s_sub_taken |=> carry_flag == ($past(alu_req.operand_a)
      >= $past(alu_req.operand_b)))
    else $error("carry is not inverted borrow after subtract");

  a_sub_half_borrow: assert property (
    @(posedge clk) disable iff (srst)
    s_sub_taken |=> half_carry_flag == ($past(alu_req.operand_a[3:0])
      >= $past(alu_req.operand_b[3:0])))
    else $error("half-carry is not inverted nibble borrow");

  a_sub_result: assert property (
    @(posedge clk) disable iff (srst)
    s_sub_taken |=> alu_result == $past(alu_req.operand_a)
      - $past(alu_req.operand_b))
    else $error("subtract result wrong");

  a_zero_add: assert property (
    @(posedge clk) disable iff (srst)
    s_add_taken
    |=> zero_flag == (($past(alu_req.operand_a)
      + $past(alu_req.operand_b)) == 8'h00)
      && carry_flag == (({1'b0, $past(alu_req.operand_a)}
      + {1'b0, $past(alu_req.operand_b)}) > 9'h0FF))
    else $error("zero or carry wrong after add");

  a_zero_sub: assert property (
    @(posedge clk) disable iff (srst)
    s_sub_taken |=> zero_flag
      == ($past(alu_req.operand_a) == $past(alu_req.operand_b)))
    else $error("zero flag wrong after subtract");

  a_zero_logic: assert property (
    @(posedge clk) disable iff (srst)
    s_logic_taken |=> zero_flag
      == ($past(alu_req.logic_result) == 8'h00))
    else $error("zero flag wrong after logic operation");

  a_logic_keeps_carry: assert property (
    @(posedge clk) disable iff (srst)
    s_logic_taken |=> $stable(half_carry_flag)
      && $stable(carry_flag))
    else $error("logic operation moved a carry flag");

  a_flag_write: assert property (
    @(posedge clk) disable iff (srst)
    s_flag_write_taken
    |=> zero_flag == $past(reg_req.wdata[ZERO_BIT])
      && half_carry_flag == $past(reg_req.wdata[HALF_CARRY_BIT])
      && carry_flag == $past(reg_req.wdata[CARRY_BIT]))
    else $error("software write did not land in writable flags");

  a_read_only_flags: assert property (
    @(posedge clk) disable iff (srst)
    ce && reg_req.write && core_event == '0
    |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("software write moved a read-only flag");

  a_upper_bits_zero: assert property (
    @(posedge clk) disable iff (srst)
    ce && reg_req.read && reg_req.addr == STATUS_FLAGS_OFFSET
    |=> rdata[7:5] == 3'h0)
    else $error("unimplemented status bits read nonzero");

  a_status_readback: assert property (
    @(posedge clk) disable iff (srst)
    ce && reg_req.read && reg_req.addr == STATUS_FLAGS_OFFSET
    |=> rdata[TIMEOUT_BIT] == $past(timeout_flag)
      && rdata[POWERDOWN_BIT] == $past(powerdown_flag)
      && rdata[ZERO_BIT] == $past(zero_flag)
      && rdata[HALF_CARRY_BIT] == $past(half_carry_flag)
      && rdata[CARRY_BIT] == $past(carry_flag))
    else $error("flag register read does not match the flags");

  a_other_reset_keep: assert property (
    @(posedge clk) disable iff (srst)
    ce && other_reset |=> $stable(zero_flag)
      && $stable(half_carry_flag) && $stable(carry_flag))
    else $error("arithmetic flags changed on other reset");

  a_frozen_state: assert property (
    @(posedge clk) disable iff (srst)
    !ce |=> $stable(timeout_flag) && $stable(powerdown_flag)
      && $stable(zero_flag) && $stable(half_carry_flag)
      && $stable(carry_flag) && $stable(rdata) && $stable(alu_result))
    else $error("state moved while clock enable was low");

endmodule

// ===== src/status_flag_pkg.sv
// Purpose: Shared constants and types for the core status flag logic
// Assumes: 8-bit data path, one clock, synchronous reset
// Notes: Register port reaches the flag register at a chosen offset
package status_flag_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] STATUS_FLAGS_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] RESET_CAUSE_OFFSET = 4'h1;

  // Field positions in the flag register
  localparam int CARRY_BIT = 0;
  localparam int HALF_CARRY_BIT = 1;
  localparam int ZERO_BIT = 2;
  localparam int POWERDOWN_BIT = 3;
  localparam int TIMEOUT_BIT = 4;
  localparam int NIBBLE_W = 4;

  // Reset values
  localparam logic TIMEOUT_RESET = 1'h1;
  localparam logic POWERDOWN_RESET = 1'h1;
  localparam logic [2:0] ARITH_FLAGS_RESET = 3'h0;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [2:0]
  {
    op_none,
    op_add,
    op_sub,
    op_logic
  } alu_op_type;

  // One instruction result presented by the core
  typedef struct packed
  {
    alu_op_type op;
    logic [DATA_W-1:0] operand_a;
    logic [DATA_W-1:0] operand_b;
    logic [DATA_W-1:0] logic_result;
  } alu_req_type;

  // Core events that move the time-out and power-down flags
  typedef struct packed
  {
    logic watchdog_clear_instr;
    logic sleep_instr;
    logic watchdog_timeout;
  } core_event_type;

  typedef struct packed
  {
    logic write;
    logic read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

endpackage

// ===== testbench/core_status_flag_logic_tb.sv
// Purpose: Self-checking bench for the core status flag logic
// Assumes: ce held high except in the clock-enable test; bench drives all ports directly
// Notes: Expected flags are recomputed here from operands
`timescale 1ns/1ps
module core_status_flag_logic_tb;
  import status_flag_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic other_reset = 1'b0;
  core_event_type core_event = '0;
  alu_req_type alu_req = '0;
  reg_req_type reg_req = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] alu_result;
  logic timeout_flag, powerdown_flag, zero_flag;
  logic half_carry_flag, carry_flag;
  int num_errors = 0;
  int comparisons = 0;

  core_status_flag_logic core_status_flag_logic_inst (.clk(clk),
    .srst(srst), .ce(ce), .other_reset(other_reset),
    .core_event(core_event), .alu_req(alu_req), .reg_req(reg_req),
    .rdata(rdata), .alu_result(alu_result), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .zero_flag(zero_flag),
    .half_carry_flag(half_carry_flag), .carry_flag(carry_flag));

  always #2.5 clk = ~clk;

  task check(input logic [7:0] got, input logic [7:0] exp, input string w);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask

  task reg_access(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr, !wr, a, d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask

  task alu_step(input alu_op_type op, input logic [7:0] a, b, lr);
    @(posedge clk);
    alu_req <= '{op, a, b, lr};
    @(posedge clk);
    alu_req <= '0;
    #1;
  endtask

  task event_step(input core_event_type ev, input logic [1:0] exp);
    @(posedge clk);
    core_event <= ev;
    @(posedge clk);
    core_event <= '0;
    #1;
    check({6'h00, timeout_flag, powerdown_flag}, {6'h00, exp}, "to pd");
  endtask

  task test_reset_values;
    check({3'h0, timeout_flag, powerdown_flag, zero_flag, half_carry_flag,
      carry_flag}, 8'h18, "reset flags");
    reg_access(1'b0, STATUS_FLAGS_OFFSET, 8'h00);
    check(rdata, 8'h18, "reset read");
  endtask

  task automatic test_arith;
    logic [7:0] av [9] = '{8'h05, 8'h03, 8'h05, 8'h8F, 8'h12, 8'h00,
      8'hFF, 8'h10, 8'h80};
    logic [7:0] bv [9] = '{8'h03, 8'h05, 8'h05, 8'h71, 8'h34, 8'h00,
      8'h01, 8'h01, 8'h80};
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] want;
    logic [7:0] seen;
    for (int i = 0; i < 18; i++)
    begin
      // Subtraction adds the complement plus one, carries taken from that
      s = (i < 9) ? {1'b0, av[i % 9]} + {1'b0, bv[i % 9]} :
        {1'b0, av[i % 9]} + {1'b0, ~bv[i % 9]} + 9'h001;
      h = (i < 9) ? {1'b0, av[i % 9][3:0]} + {1'b0, bv[i % 9][3:0]} :
        {1'b0, av[i % 9][3:0]} + {1'b0, ~bv[i % 9][3:0]} + 5'h01;
      alu_step((i < 9) ? op_add : op_sub, av[i % 9], bv[i % 9], 8'hA5);
      check(alu_result, s[7:0], "sum");
      want = {5'h00, (s[7:0] == 8'h00), h[4], s[8]};
      seen = {5'h00, zero_flag, half_carry_flag, carry_flag};
      check(seen, want, "flags");
    end
    // Logic result of zero moves only the zero flag
    alu_step(op_logic, 8'h00, 8'h00, 8'h00);
    check({7'h00, zero_flag}, 8'h01, "logic zero");
    alu_step(op_logic, 8'hFF, 8'hFF, 8'h40);
    check({7'h00, zero_flag}, 8'h00, "logic nonzero");
  endtask

  task test_register;
    reg_access(1'b1, STATUS_FLAGS_OFFSET, 8'hFF);
    reg_access(1'b0, STATUS_FLAGS_OFFSET, 8'h00);
    check(rdata, 8'h1F, "write ones");
    reg_access(1'b1, STATUS_FLAGS_OFFSET, 8'h00);
    reg_access(1'b0, STATUS_FLAGS_OFFSET, 8'h00);
    check(rdata, 8'h18, "write zeros");
    reg_access(1'b0, 4'hF, 8'h00);
    check(rdata, UNMAPPED_READ, "unmapped read");
  endtask

  task test_events;
    event_step('{1'b0, 1'b1, 1'b0}, 2'b10);
    event_step('{1'b0, 1'b0, 1'b1}, 2'b00);
    event_step('{1'b1, 1'b0, 1'b0}, 2'b11);
  endtask

  task test_other_reset;
    reg_access(1'b1, STATUS_FLAGS_OFFSET, 8'h07);
    @(posedge clk);
    other_reset <= 1'b1;
    @(posedge clk);
    other_reset <= 1'b0;
    reg_access(1'b0, STATUS_FLAGS_OFFSET, 8'h00);
    check({5'h00, rdata[2:0]}, 8'h07, "kept over reset");
    reg_access(1'b0, RESET_CAUSE_OFFSET, 8'h00);
    check(rdata, 8'h01, "reset cause set");
    // Second power-on reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({3'h0, timeout_flag, powerdown_flag, zero_flag, half_carry_flag,
      carry_flag}, 8'h18, "second power-on");
    reg_access(1'b0, RESET_CAUSE_OFFSET, 8'h00);
    check(rdata, 8'h00, "reset cause cleared");
  endtask

  // Flags 1B and result 40 are what the arith and event scenarios leave
  task test_clock_enable;
    @(posedge clk);
    ce <= 1'b0;
    alu_step(op_add, 8'hFF, 8'h01, 8'h00);
    event_step('{1'b0, 1'b1, 1'b0}, 2'b11);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    check({3'h0, timeout_flag, powerdown_flag, zero_flag, half_carry_flag,
      carry_flag}, 8'h1B, "frozen flags");
    check(alu_result, 8'h40, "frozen result");
  endtask

  task close_out;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    test_reset_values();
    test_register();
    test_arith();
    test_events();
    test_clock_enable();
    test_other_reset();
    close_out();
  end

  // Whole run needs well under 200 cycles
  initial
  begin
    #(5 * 2000);
    num_errors++;
    close_out();
  end
endmodule
